/* File: rtl/pbs_pkg.sv */
// Constants and types for the pipelined burst SRAM access logic.
// Assumes one rising-edge clock and a synchronous active-high reset.
package pbs_pkg;

  localparam int  ADDR_W_DEF     = 10;
  localparam int  LANES_DEF      = 4;
  localparam int  LANE_W         = 9;
  localparam int  BURST_W        = 2;
  localparam int  SLEEP_ENTER_CYC = 2;
  localparam int  SLEEP_EXIT_CYC  = 2;
  localparam logic [1:0] BURST_STEP = 2'h1;
  localparam logic [1:0] SLEEP_CNT_RST = 2'h0;

  typedef enum logic [1:0]
  {
    ST_DESEL  = 2'h0,
    ST_READ   = 2'h1,
    ST_WRITE  = 2'h2,
    ST_PWRITE = 2'h3
  } pbs_state_t;

endpackage : pbs_pkg

/* File: rtl/pbs_sram.sv */
// Synchronous access logic and storage array of a pipelined burst SRAM.
// Assumes the far party keeps output enable high while it drives data,
// deselects before sleep and holds selects idle two cycles after sleep.
module pbs_sram #(
  parameter int ADDR_W = pbs_pkg::ADDR_W_DEF,
  parameter int LANES  = pbs_pkg::LANES_DEF
)(
  // Clock and reset
  input  wire logic                          SYS_CLK,
  input  wire logic                          SYS_RST,
  // Address and strobes
  input  wire logic [ADDR_W-1:0]             ADDR,
  input  wire logic                          PROCESSOR_ADDR_STROBE_N,
  input  wire logic                          CONTROLLER_ADDR_STROBE_N,
  input  wire logic                          BURST_ADVANCE_N,
  // Chip selects
  input  wire logic                          CHIP_SELECT_FIRST_N,
  input  wire logic                          CHIP_SELECT_SECOND,
  input  wire logic                          CHIP_SELECT_THIRD_N,
  // Write controls
  input  wire logic                          GLOBAL_WRITE_N,
  input  wire logic                          BYTE_WRITE_ENABLE_N,
  input  wire logic [LANES-1:0]              BYTE_LANE_SELECT_N,
  // Mode, output enable, sleep
  input  wire logic                          BURST_ORDER_LINEAR_N,
  input  wire logic                          OUTPUT_ENABLE_N,
  input  wire logic                          SLEEP_REQUEST,
  // Data lanes, data plus parity per lane
  input  wire logic [LANES*pbs_pkg::LANE_W-1:0] DATA_IN,
  output logic      [LANES*pbs_pkg::LANE_W-1:0] DATA_OUT,
  output logic                               DATA_OE,
  output logic                               SLEEP_ACTIVE
);

  localparam int DW = LANES * pbs_pkg::LANE_W;

  ////////////////////////////////////////////////////////////////////////////
  // Input registers

  logic [ADDR_W-1:0] addr_in_r;
  logic              psn_r;
  logic              csn_r;
  logic              advn_r;
  logic              ce1n_r;
  logic              ce2_r;
  logic              ce3n_r;
  logic              gwn_r;
  logic              bwen_r;
  logic [LANES-1:0]  bsn_r;
  logic [DW-1:0]     din_r;
  logic              linear_n_r;
  logic              oen_r;
  logic              zz_r;

  always_ff @(posedge SYS_CLK)
  begin
    addr_in_r  <= ADDR;
    psn_r      <= PROCESSOR_ADDR_STROBE_N;
    csn_r      <= CONTROLLER_ADDR_STROBE_N;
    advn_r     <= BURST_ADVANCE_N;
    ce1n_r     <= CHIP_SELECT_FIRST_N;
    ce2_r      <= CHIP_SELECT_SECOND;
    ce3n_r     <= CHIP_SELECT_THIRD_N;
    gwn_r      <= GLOBAL_WRITE_N;
    bwen_r     <= BYTE_WRITE_ENABLE_N;
    bsn_r      <= BYTE_LANE_SELECT_N;
    din_r      <= DATA_IN;
    linear_n_r <= BURST_ORDER_LINEAR_N;
    oen_r      <= OUTPUT_ENABLE_N;
    zz_r       <= SLEEP_REQUEST;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle decode on registered inputs

  logic       sleep_r;
  wire        awake      = !sleep_r;
  wire        sel_all    = !ce1n_r && ce2_r && !ce3n_r;
  // Processor strobe only counts with first select low
  wire        ps_valid   = !psn_r && !ce1n_r;
  wire        cs_valid   = !csn_r && psn_r;
  wire        strobe     = ps_valid || cs_valid;
  wire        any_strobe = !psn_r || !csn_r;
  wire        wr_req     = !gwn_r || (!bwen_r && (bsn_r != '1));
  wire        deselect   = awake && any_strobe && !sel_all && !ps_valid;
  wire        ps_start   = awake && ps_valid && sel_all;
  wire        cs_write   = awake && cs_valid && sel_all && wr_req;
  wire        cs_read    = awake && cs_valid && sel_all && !wr_req;
  wire        new_access = ps_start || cs_valid && sel_all && awake;
  wire        no_strobe  = awake && !any_strobe;

  wire [LANES-1:0] lane_we;
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      // Global write wins over all byte controls
      assign lane_we[g] = !gwn_r || (!bwen_r && !bsn_r[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Burst counter and state

  pbs_pkg::pbs_state_t state_r;
  pbs_pkg::pbs_state_t state_nxt;
  logic [ADDR_W-1:0]   base_r;
  logic [1:0]          start_r;
  logic [1:0]          cnt_r;
  logic [1:0]          cnt_nxt;

  wire  [1:0] low_lin  = start_r + cnt_r;
  wire  [1:0] low_int  = start_r ^ cnt_r;
  wire  [1:0] low_bits = linear_n_r ? low_int : low_lin;
  wire  [ADDR_W-1:0] burst_addr = {base_r[ADDR_W-1:2], low_bits};
  wire  [ADDR_W-1:0] eff_addr   = new_access ? addr_in_r : burst_addr;

  // Processor-strobe write resolves at the second edge only
  wire  pw_commit  = (state_r == pbs_pkg::ST_PWRITE) && no_strobe && wr_req;
  wire  cont_write = (state_r == pbs_pkg::ST_WRITE) && no_strobe && wr_req;
  wire  do_write   = cs_write || pw_commit || cont_write;
  wire  read_cyc   = cs_read || ((state_r == pbs_pkg::ST_READ ||
                     state_r == pbs_pkg::ST_PWRITE) && no_strobe && !wr_req);
  wire  is_write   = do_write || ps_start;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    if (!awake)
      state_nxt = pbs_pkg::ST_DESEL;
    else if (deselect)
      state_nxt = pbs_pkg::ST_DESEL;
    else if (ps_start)
      state_nxt = pbs_pkg::ST_PWRITE;
    else if (cs_write)
      state_nxt = pbs_pkg::ST_WRITE;
    else if (cs_read)
      state_nxt = pbs_pkg::ST_READ;
    else if (no_strobe && state_r != pbs_pkg::ST_DESEL)
      state_nxt = wr_req ? pbs_pkg::ST_WRITE : pbs_pkg::ST_READ;
    if (new_access)
      cnt_nxt = '0;
    else if (no_strobe && !advn_r && state_r != pbs_pkg::ST_DESEL)
      cnt_nxt = cnt_r + pbs_pkg::BURST_STEP;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      state_r <= pbs_pkg::ST_DESEL;
      cnt_r   <= '0;
      base_r  <= '0;
      start_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (new_access)
      begin
        base_r  <= addr_in_r;
        start_r <= addr_in_r[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage array and output register

  logic [DW-1:0] mem [2**ADDR_W];
  logic [DW-1:0] rd_word;
  logic [DW-1:0] wr_word;

  assign rd_word = mem[eff_addr];

  always_comb
  begin
    wr_word = rd_word;
    for (int i = 0; i < LANES; i++)
      if (lane_we[i])
        wr_word[i*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] =
          din_r[i*pbs_pkg::LANE_W +: pbs_pkg::LANE_W];
  end

  // No reset on the array: contents survive sleep and reset alike
  always_ff @(posedge SYS_CLK)
  begin
    if (do_write && !SYS_RST)
      mem[eff_addr] <= wr_word;
  end

  logic first_r;

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      DATA_OUT <= '0;
      DATA_OE  <= 1'b0;
      first_r  <= 1'b0;
    end
    else
    begin
      if (read_cyc)
        DATA_OUT <= rd_word;
      // Processor strobe out of deselect: mask its first read cycle too
      first_r  <= ps_start && state_r == pbs_pkg::ST_DESEL;
      DATA_OE  <= read_cyc && !is_write && !OUTPUT_ENABLE_N &&
                  state_r != pbs_pkg::ST_DESEL && !first_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep sequencing

  logic [1:0] sleep_cnt_r;
  // Entry and exit may differ in length, so each has its own limit
  wire  [1:0] sleep_lim = zz_r ? 2'(pbs_pkg::SLEEP_ENTER_CYC - 1) :
                                 2'(pbs_pkg::SLEEP_EXIT_CYC - 1);

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      sleep_r     <= 1'b0;
      sleep_cnt_r <= pbs_pkg::SLEEP_CNT_RST;
      SLEEP_ACTIVE <= 1'b0;
    end
    else
    begin
      if (zz_r != sleep_r)
        sleep_cnt_r <= sleep_cnt_r + 2'h1;
      else
        sleep_cnt_r <= pbs_pkg::SLEEP_CNT_RST;
      if (zz_r != sleep_r && sleep_cnt_r == sleep_lim)
      begin
        sleep_r      <= zz_r;
        SLEEP_ACTIVE <= zz_r;
        sleep_cnt_r  <= pbs_pkg::SLEEP_CNT_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_write_hiz: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    is_write |=> !DATA_OE)
    else $error("Data driven after write cycle");

  a_desel_hiz: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    deselect |=> !DATA_OE && state_r == pbs_pkg::ST_DESEL)
    else $error("Outputs live after deselect");

  a_first_mask: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (read_cyc && state_r == pbs_pkg::ST_DESEL) |=> !DATA_OE)
    else $error("First read cycle not masked");

  a_oe_gate: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    DATA_OE |-> !$past(OUTPUT_ENABLE_N))
    else $error("Driven while output enable high");

  a_ps_two: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    ps_start |-> !do_write ##1 state_r == pbs_pkg::ST_PWRITE)
    else $error("Processor write not two-cycle");

  a_burst_load: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    new_access |=> cnt_r == 2'h0 && start_r == $past(addr_in_r[1:0]))
    else $error("Burst counter not loaded");

  a_burst_adv: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (no_strobe && !advn_r && state_r != pbs_pkg::ST_DESEL) |=>
      cnt_r == $past(cnt_r) + 2'h1)
    else $error("Burst counter did not advance");

  a_burst_hold: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (no_strobe && advn_r) |=> $stable(cnt_r))
    else $error("Burst address moved without advance");

  a_order_sel: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    low_bits == (linear_n_r ? (start_r ^ cnt_r) : 2'(start_r + cnt_r)))
    else $error("Burst order wrong");

  a_sleep_two: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $rose(sleep_r) |-> $past(zz_r, 2))
    else $error("Sleep entered early");

  a_sleep_exit: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $fell(sleep_r) |-> !$past(zz_r, 2))
    else $error("Sleep left early");

  a_ps_first: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    first_r |=> !DATA_OE)
    else $error("Processor read first cycle driven");

  a_cs_commit: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    cs_write |-> do_write)
    else $error("Controller write not stored");

  a_sleep_idle: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !awake |-> !do_write)
    else $error("Write while asleep");

  a_global_all: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (do_write && !gwn_r) |-> lane_we == '1)
    else $error("Global write missed a lane");

  a_byte_only: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (do_write && gwn_r) |-> lane_we == ~bsn_r)
    else $error("Byte write lanes wrong");

  a_pw_commit: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    pw_commit |-> $past(ps_start))
    else $error("Processor write committed early");

endmodule : pbs_sram

/* File: test/pbs_host_model.sv */
// Host model driving the burst SRAM bus.
// Assumes tasks are called right after a rising clock edge.
module pbs_host_model (
  // Clock
  input  wire logic        clk,
  // Bus towards the memory
  output logic [9:0]       addr,
  output logic             ps_n,
  output logic             cs_n,
  output logic             adv_n,
  output logic             ce1_n,
  output logic             ce3_n,
  output logic             gw_n,
  output logic             bwe_n,
  output logic [3:0]       sel_n,
  output logic [35:0]      dat,
  output logic             oe_n,
  output logic             slp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic break_oe = 1'b0;
  initial
  begin
    {addr, ps_n, cs_n, adv_n, ce1_n, ce3_n} = {10'h000, 5'h1F};
    {gw_n, bwe_n, sel_n, dat, oe_n, slp} = {6'h3F, 36'h0, 2'h2};
  end
  ////////////////////////////////////////////////////////////////////////////
  // Kind: 0 none, 1 deselect, 2 controller, 3 processor, 4 both strobes
  task automatic bus(input int kind, input logic [9:0] a, input logic burst_advance_n, input logic gw,
                     input logic byte_write_enable_n, input logic [3:0] sel, input logic [35:0] d,
                     input logic oe);
    logic wr;
    wr = !gw || (!byte_write_enable_n && sel != 4'hF);
    addr <= a;
    ps_n <= !(kind == 3 || kind == 4);
    cs_n <= !(kind == 1 || kind == 2 || kind == 4);
    ce1_n <= (kind == 1);
    ce3_n <= (kind == 1);
    adv_n <= burst_advance_n;
    gw_n <= gw;
    bwe_n <= byte_write_enable_n;
    sel_n <= sel;
    // All lanes toggle on calls without a write so stale data never looks valid
    dat <= wr ? d : ~dat;
    oe_n <= (wr && !break_oe) ? 1'b1 : oe;
    @(posedge clk);
  endtask : bus
  task automatic sleep_set(input logic s);
    slp <= s;
    ce1_n <= 1'b1;
    ce3_n <= 1'b1;
    ps_n <= 1'b1;
    cs_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : sleep_set
endmodule : pbs_host_model

/* File: test/pipelined_burst_sram_access_tb.sv */
// Self-checking bench for pbs_sram with a reference model.
// Assumes pbs_host_model drives the bus side.
module pipelined_burst_sram_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ord_n = 1'b1;
  logic [9:0]  a_w;
  logic [3:0]  sel_n;
  logic [35:0] din, dout;
  logic        ps_n, cs_n, adv_n, ce1_n, ce3_n, gw_n, bwe_n, oe_n, slp, doe, sact;
  int          err_count = 0;
  int          num_checks = 0;
  int          now = 0;
  int          tcount = 0;
  logic [31:0] xs = 32'hC46D;
  logic [35:0] mem [int];
  logic [35:0] exp_dat [int];
  logic        exp_oe [int];
  pbs_host_model u_host (.clk(clk), .addr(a_w), .ps_n(ps_n), .cs_n(cs_n), .adv_n(adv_n),
    .ce1_n(ce1_n), .ce3_n(ce3_n), .gw_n(gw_n), .bwe_n(bwe_n), .sel_n(sel_n), .dat(din),
    .oe_n(oe_n), .slp(slp));
  pbs_sram #(.ADDR_W(10), .LANES(4)) u_pbs_sram (.SYS_CLK(clk), .SYS_RST(rst), .ADDR(a_w),
    .PROCESSOR_ADDR_STROBE_N(ps_n), .CONTROLLER_ADDR_STROBE_N(cs_n), .BURST_ADVANCE_N(adv_n),
    .CHIP_SELECT_FIRST_N(ce1_n), .CHIP_SELECT_SECOND(1'b1), .CHIP_SELECT_THIRD_N(ce3_n),
    .GLOBAL_WRITE_N(gw_n), .BYTE_WRITE_ENABLE_N(bwe_n), .BYTE_LANE_SELECT_N(sel_n),
    .BURST_ORDER_LINEAR_N(ord_n), .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(slp),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe), .SLEEP_ACTIVE(sact));
  always #10 clk = ~clk;
  always @(negedge clk) now <= now + 1;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    return xs;
  endfunction : rnd
  function automatic logic [35:0] rd36();
    logic [63:0] t;
    t = {rnd(), rnd()};
    return t[35:0];
  endfunction : rd36
  function automatic void mwr(int a, logic gw, logic byte_write_enable_n, logic [3:0] sel, logic [35:0] d);
    for (int i = 0; i < 4; i++)
      if (!gw || (!byte_write_enable_n && !sel[i]))
        mem[a][9*i+:9] = d[9*i+:9];
  endfunction : mwr
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    #1;
    if (exp_oe.exists(now))
      chk("output enable", 36'(doe), 36'(exp_oe[now]));
    if (exp_dat.exists(now))
      chk("read data", dout, exp_dat[now]);
  end
  // Ceiling well above the roughly 90 cycles of the sequence
  always @(posedge clk)
  begin
    tcount <= tcount + 1;
    if (tcount == 2000)
    begin
      err_count++;
      end_of_test();
    end
  end
  initial
  begin : main
    int b, a;
    logic [35:0] d;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    b = int'(rnd() & 32'h3FC);
    for (int i = 0; i < 4; i++)
    begin
      d = rd36();
      mwr(b + i, 1'b0, 1'b1, 4'hF, d);
      u_host.break_oe = (i == 3);
      if (i == 3)
        exp_oe[now + 2] = 1'b0;
      u_host.bus(2, 10'(b + i), 1'b0, 1'b0, 1'b1, 4'h0, d, 1'b0);
    end
    for (int s = 0; s < 16; s++)
    begin
      d = rd36();
      mwr(b + 1, 1'b1, 1'b0, 4'(s), d);
      u_host.bus(2, 10'(b + 1), 1'b1, 1'b1, 1'b0, 4'(s), d, 1'b0);
      u_host.break_oe = 1'b0;
    end
    d = rd36();
    u_host.bus(3, 10'(b + 2), 1'b0, 1'b0, 1'b1, 4'h0, ~d, 1'b0);
    mwr(b + 2, 1'b1, 1'b0, 4'hE, d);
    u_host.bus(0, 10'(rnd()), 1'b1, 1'b1, 1'b0, 4'hE, d, 1'b0);
    exp_dat[now + 3] = mem[b + 3];
    u_host.bus(4, 10'(b + 3), 1'b1, 1'b0, 1'b1, 4'hF, rd36(), 1'b0);
    u_host.bus(0, 10'(rnd()), 1'b1, 1'b1, 1'b1, 4'hF, 36'h0, 1'b0);
    $display("test writes done");
    for (int m = 0; m < 2; m++)
      for (int s = 0; s < 4; s++)
      begin
        ord_n <= m[0];
        exp_oe[now + 3] = 1'b0;
        u_host.bus(1, 10'h0, 1'b1, 1'b1, 1'b1, 4'hF, 36'h0, 1'b0);
        for (int k = 0; k < 5; k++)
        begin
          a = (k < 4) ? k : 3;
          a = m ? (s ^ a) : ((s + a) & 3);
          exp_dat[now + 3] = mem[b + a];
          // Enable pin is taken one cycle ahead; call k+2 gates word k
          exp_oe[now + 3] = (k == 1 || k == 3);
          u_host.bus(k ? 0 : 3, k ? 10'(rnd()) : 10'(b + s), k == 0 || k == 4,
                     1'b1, 1'b1, 4'hF, 36'h0, k == 4);
        end
      end
    $display("test bursts done");
    u_host.bus(1, 10'h0, 1'b1, 1'b1, 1'b1, 4'hF, 36'h0, 1'b0);
    u_host.sleep_set(1'b1);
    #1 chk("sleep entry", 36'(sact), 36'h1);
    @(posedge clk);
    u_host.sleep_set(1'b0);
    #1 chk("sleep exit", 36'(sact), 36'h0);
    @(posedge clk);
    exp_dat[now + 3] = mem[b];
    u_host.bus(3, 10'(b), 1'b1, 1'b1, 1'b1, 4'hF, 36'h0, 1'b0);
    repeat (4) u_host.bus(0, 10'h0, 1'b1, 1'b1, 1'b1, 4'hF, 36'h0, 1'b0);
    $display("test sleep done");
    end_of_test();
  end
endmodule : pipelined_burst_sram_access_tb
